// *** trg_cfg.svh ***
// constants for the true random generator: offsets, fields, resets
// assumes inclusion by trg_pkg and trg_top; definitions only
`ifndef TRG_CFG_SVH
`define TRG_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TRG_ADDR_CTRL 8'h00
`define TRG_ADDR_CFG 8'h04
`define TRG_ADDR_CMD 8'h08
`define TRG_ADDR_RESULT 8'h0c
`define TRG_ADDR_GPOLY 8'h10
`define TRG_ADDR_FPOLY 8'h14
`define TRG_ADDR_MONCTL 8'h18
`define TRG_ADDR_RCCFG 8'h1c
`define TRG_ADDR_APCFG 8'h20
`define TRG_ADDR_RCSTAT 8'h24
`define TRG_ADDR_APSTAT 8'h28
`define TRG_ADDR_EVENT 8'h2c

// ----------------------------------------
// field positions
// ----------------------------------------
`define TRG_CTL_ON 5:0
`define TRG_CTL_HALT_RC 8
`define TRG_CTL_HALT_AP 9
`define TRG_CFG_SIZE 5:0
`define TRG_CFG_RLEN 11:8
`define TRG_CFG_RED_EN 12
`define TRG_CFG_COR_EN 13
`define TRG_CFG_SEL 15:14
`define TRG_CFG_DIV 23:16
`define TRG_CFG_INIT 31:24
`define TRG_CMD_START 0
`define TRG_MON_RC 0
`define TRG_MON_AP 1
`define TRG_POLY 30:0
`define TRG_AP_CUT 15:0
`define TRG_AP_WIN 31:16
`define TRG_SRC_GFLEX 3
`define TRG_SRC_FFLEX 5
`define TRG_EV_RC 0
`define TRG_EV_AP 1
`define TRG_EV_ALL 1:0
`define TRG_RC_CUT 7:0
`define TRG_RCS_BIT 0
`define TRG_RCS_TALLY 15:8

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define TRG_CFG_RESET 32'h0000_0020
`define TRG_ZERO32 32'h0000_0000
`define TRG_MAX_SIZE 6'h20
`define TRG_PAD_POLY 1'h0

`endif

// *** trg_pkg.sv ***
// types for the true random generator
// assumes trg_cfg.svh in the include path
`include "trg_cfg.svh"

package trg_pkg;

	// ----------------------------------------
	// monitored stream choice
	// ----------------------------------------
	typedef enum logic [1:0] {
		TRG_MON_SAMPLED,
		TRG_MON_FOLDED,
		TRG_MON_CORRECTED
	} trg_sel_t;

	// ----------------------------------------
	// drive towards the ring oscillators
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] source_on_bits;
		logic [30:0] galois_poly;
		logic [30:0] fibonacci_poly;
	} trg_osc_drive_t;

	// ----------------------------------------
	// whole block state
	// ----------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [5:0] src_on;
		logic halt_on_repeat_fail;
		logic halt_on_proportion_fail;
		logic [31:0] cfg;
		logic [30:0] gpoly;
		logic [30:0] fpoly;
		trg_osc_drive_t drive;
		logic busy;
		logic [31:0] entropy_output;
		logic [31:0] shift;
		logic [5:0] bitcnt;
		logic [7:0] div_cnt;
		logic tick;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [7:0] init_cnt;
		logic any_on;
		logic acc;
		logic [3:0] red_cnt;
		logic pair_have;
		logic pair_first;
		logic repeat_test_run;
		logic proportion_test_run;
		logic [7:0] rc_threshold;
		logic [15:0] ap_threshold;
		logic [15:0] ap_window;
		logic rc_bit;
		logic [7:0] same_value_tally;
		logic ap_bit;
		logic [15:0] hit_tally;
		logic [15:0] ap_index;
		logic ap_fresh;
		logic [1:0] events;
	} trg_state_t;

endpackage

// *** trg_top.sv ***
// true random generator: sampling, folding, correction, monitor, apb slave
// assumes ring oscillators outside driving osc_raw asynchronously
`timescale 1ns/1ps
`include "trg_cfg.svh"

module trg_top (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// ring oscillators
	input wire logic [5:0] osc_raw,
	output trg_pkg::trg_osc_drive_t osc_drive
);
	import trg_pkg::*;

	trg_state_t s;
	trg_state_t n;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic acc_req;
		logic sampled_noise_bit;
		logic rbit;
		logic rvld;
		logic tbit;
		logic tvld;
		logic mbit;
		logic mvld;
		logic rc_det;
		logic ap_det;
		logic [31:0] rdat;
		logic [31:0] ev_clr;
		logic go;
		acc_req = psel && penable && !s.pready;
		sampled_noise_bit = 1'b0;
		rbit = 1'b0;
		rvld = 1'b0;
		tbit = 1'b0;
		tvld = 1'b0;
		mbit = 1'b0;
		mvld = 1'b0;
		rc_det = 1'b0;
		ap_det = 1'b0;
		rdat = `TRG_ZERO32;
		ev_clr = `TRG_ZERO32;
		go = 1'b0;
		n = s;

		// ----------------------------------------
		// apb access, one wait state
		// ----------------------------------------
		n.pready = acc_req;
		n.pslverr = 1'b0;
		if (acc_req) begin
			if (paddr == `TRG_ADDR_CTRL) begin
				rdat[`TRG_CTL_ON] = s.src_on;
				rdat[`TRG_CTL_HALT_RC] = s.halt_on_repeat_fail;
				rdat[`TRG_CTL_HALT_AP] = s.halt_on_proportion_fail;
				if (pwrite) begin
					n.src_on = pwdata[`TRG_CTL_ON];
					n.halt_on_repeat_fail = pwdata[`TRG_CTL_HALT_RC];
					n.halt_on_proportion_fail = pwdata[`TRG_CTL_HALT_AP];
				end
			end else if (paddr == `TRG_ADDR_CFG) begin
				rdat = s.cfg;
				if (pwrite) begin
					n.cfg = pwdata;
					if (pwdata[`TRG_CFG_SIZE] > `TRG_MAX_SIZE) begin
						n.cfg[`TRG_CFG_SIZE] = `TRG_MAX_SIZE;
					end
				end
			end else if (paddr == `TRG_ADDR_CMD) begin
				rdat[`TRG_CMD_START] = s.busy;
				if (pwrite && pwdata[`TRG_CMD_START]) begin
					go = 1'b1;
					n.busy = 1'b1;
					n.bitcnt = '0;
					n.shift = `TRG_ZERO32;
				end
			end else if (paddr == `TRG_ADDR_RESULT) begin
				rdat = s.entropy_output;
			end else if (paddr == `TRG_ADDR_GPOLY) begin
				rdat[`TRG_POLY] = s.gpoly;
				if (pwrite) begin
					n.gpoly = pwdata[`TRG_POLY];
				end
			end else if (paddr == `TRG_ADDR_FPOLY) begin
				rdat[`TRG_POLY] = s.fpoly;
				if (pwrite) begin
					n.fpoly = pwdata[`TRG_POLY];
				end
			end else if (paddr == `TRG_ADDR_MONCTL) begin
				rdat[`TRG_MON_RC] = s.repeat_test_run;
				rdat[`TRG_MON_AP] = s.proportion_test_run;
				if (pwrite) begin
					n.repeat_test_run = pwdata[`TRG_MON_RC];
					n.proportion_test_run = pwdata[`TRG_MON_AP];
					if (pwdata[`TRG_MON_RC] && !s.repeat_test_run) begin
						n.same_value_tally = '0;
					end
					if (pwdata[`TRG_MON_AP] && !s.proportion_test_run) begin
						n.ap_fresh = 1'b1;
					end
				end
			end else if (paddr == `TRG_ADDR_RCCFG) begin
				rdat[`TRG_RC_CUT] = s.rc_threshold;
				if (pwrite) begin
					n.rc_threshold = pwdata[`TRG_RC_CUT];
				end
			end else if (paddr == `TRG_ADDR_APCFG) begin
				rdat[`TRG_AP_CUT] = s.ap_threshold;
				rdat[`TRG_AP_WIN] = s.ap_window;
				if (pwrite) begin
					n.ap_threshold = pwdata[`TRG_AP_CUT];
					n.ap_window = pwdata[`TRG_AP_WIN];
				end
			end else if (paddr == `TRG_ADDR_RCSTAT) begin
				rdat[`TRG_RCS_BIT] = s.rc_bit;
				rdat[`TRG_RCS_TALLY] = s.same_value_tally;
			end else if (paddr == `TRG_ADDR_APSTAT) begin
				rdat[`TRG_AP_CUT] = s.hit_tally;
				rdat[`TRG_AP_WIN] = s.ap_index;
			end else if (paddr == `TRG_ADDR_EVENT) begin
				rdat[`TRG_EV_ALL] = s.events;
				if (pwrite) begin
					ev_clr = pwdata;
				end
			end else begin
				n.pslverr = 1'b1;
			end
		end
		n.prdata = acc_req ? rdat : `TRG_ZERO32;
		n.events = s.events & ~ev_clr[`TRG_EV_ALL];

		// ----------------------------------------
		// sample enable divider
		// ----------------------------------------
		n.tick = 1'b0;
		if (s.div_cnt >= s.cfg[`TRG_CFG_DIV]) begin
			n.div_cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.div_cnt = s.div_cnt + 8'h01;
		end

		// two sync flops clocked on sample enable
		if (s.tick) begin
			n.sync1 = osc_raw;
			n.sync2 = s.sync1;
		end
		n.sync1 = n.sync1 & s.src_on;
		n.sync2 = n.sync2 & s.src_on;

		n.any_on = |s.src_on;
		if (n.any_on && !s.any_on) begin
			n.init_cnt = s.cfg[`TRG_CFG_INIT];
		end else if (s.tick && s.init_cnt != 8'h00) begin
			n.init_cnt = s.init_cnt - 8'h01;
		end

		// ----------------------------------------
		// folding and correction
		// ----------------------------------------
		if (s.tick && s.any_on && s.init_cnt == 8'h00) begin
			sampled_noise_bit = ^s.sync2;
			if (s.cfg[`TRG_CFG_RED_EN]) begin
				if (s.red_cnt >= s.cfg[`TRG_CFG_RLEN]) begin
					rbit = s.acc ^ sampled_noise_bit;
					rvld = 1'b1;
					n.acc = 1'b0;
					n.red_cnt = '0;
				end else begin
					n.acc = s.acc ^ sampled_noise_bit;
					n.red_cnt = s.red_cnt + 4'h1;
				end
			end else begin
				rbit = sampled_noise_bit;
				rvld = 1'b1;
			end
		end
		if (rvld) begin
			if (s.cfg[`TRG_CFG_COR_EN]) begin
				// pairs, earlier bit kept on mismatch
				if (s.pair_have) begin
					n.pair_have = 1'b0;
					tbit = s.pair_first;
					tvld = s.pair_first != rbit;
				end else begin
					n.pair_have = 1'b1;
					n.pair_first = rbit;
				end
			end else begin
				tbit = rbit;
				tvld = 1'b1;
			end
		end

		// ----------------------------------------
		// result assembly
		// ----------------------------------------
		// a new start wins over a same-cycle completion
		if (s.busy && !go) begin
			// done after size bits, size 0 at once
			if (s.bitcnt >= s.cfg[`TRG_CFG_SIZE]) begin
				n.busy = 1'b0;
				n.entropy_output = s.shift;
			end else if (tvld) begin
				n.shift = {s.shift[30:0], tbit};
				n.bitcnt = s.bitcnt + 6'h01;
			end
		end

		// ----------------------------------------
		// health monitor
		// ----------------------------------------
		// stream select
		case (trg_sel_t'(s.cfg[`TRG_CFG_SEL]))
			TRG_MON_SAMPLED: begin
				mbit = sampled_noise_bit;
				mvld = s.tick && s.any_on && s.init_cnt == 8'h00;
			end
			TRG_MON_FOLDED: begin
				mbit = rbit;
				mvld = rvld;
			end
			default: begin
				mbit = tbit;
				mvld = tvld;
			end
		endcase
		if (s.repeat_test_run && mvld) begin
			if (s.same_value_tally == 8'h00 || mbit != s.rc_bit) begin
				n.rc_bit = mbit;
				n.same_value_tally = 8'h01;
			end else begin
				n.same_value_tally = s.same_value_tally + 8'h01;
			end
			if (n.same_value_tally == s.rc_threshold) begin
				rc_det = 1'b1;
				n.repeat_test_run = 1'b0;
			end
		end
		if (s.proportion_test_run && mvld) begin
			if (s.ap_fresh || s.ap_index + 16'h0001 >= s.ap_window) begin
				n.ap_fresh = 1'b0;
				n.ap_bit = mbit;
				n.ap_index = '0;
				n.hit_tally = 16'h0001;
			end else begin
				n.ap_index = s.ap_index + 16'h0001;
				if (mbit == s.ap_bit) begin
					n.hit_tally = s.hit_tally + 16'h0001;
				end
			end
			if (n.hit_tally == s.ap_threshold) begin
				ap_det = 1'b1;
				n.proportion_test_run = 1'b0;
			end
		end
		// set wins over software clear
		if (rc_det) begin
			n.events[`TRG_EV_RC] = 1'b1;
		end
		if (ap_det) begin
			n.events[`TRG_EV_AP] = 1'b1;
		end
		if ((rc_det && s.halt_on_repeat_fail) ||
			(ap_det && s.halt_on_proportion_fail)) begin
			n.src_on = '0;
		end

		n.drive.source_on_bits = n.src_on;
		n.drive.galois_poly = n.src_on[`TRG_SRC_GFLEX] ? n.gpoly : '0;
		n.drive.fibonacci_poly = n.src_on[`TRG_SRC_FFLEX] ? n.fpoly : '0;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.cfg <= `TRG_CFG_RESET;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign osc_drive = s.drive;

endmodule // trg_top

// *** trg_top_checker.sv ***
// checker for trg_top: apb answer timing, oscillator drive
// assumes binding to trg_top on the single pclk domain
`timescale 1ns/1ps

module trg_top_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// rings
	input wire logic [5:0] osc_raw,
	input wire trg_pkg::trg_osc_drive_t osc_drive
);
	import trg_pkg::*;
	// ----
	// helpers
	// ----
	logic wr_ctl;
	logic [5:0] on_q;
	assign wr_ctl = psel && penable && pwrite && !pready && paddr == 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) on_q <= 6'h00;
		else if (wr_ctl) on_q <= pwdata[5:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// properties
	// ----
	gal_off_a: assert property (
		!osc_drive.source_on_bits[3] |-> osc_drive.galois_poly == '0)
		else $error("galois poly live while off");
	fib_off_a: assert property (
		!osc_drive.source_on_bits[5] |-> osc_drive.fibonacci_poly == '0)
		else $error("fibonacci poly live while off");
	ctl_apply_a: assert property (
		wr_ctl && pwdata[9:8] == 2'b00
		|=> ##[0:1] osc_drive.source_on_bits == on_q)
		else $error("enables not applied");
	src_hold_a: assert property (
		!$stable(osc_drive.source_on_bits) |-> $past(wr_ctl)
		|| $past(wr_ctl, 2) || osc_drive.source_on_bits == 6'h00)
		else $error("enables changed without cause");
	rdy_pulse_a: assert property (
		pready |=> !pready) else $error("answer longer than a cycle");
	rdy_next_a: assert property (
		psel && penable && !pready |=> pready) else $error("answer late");
	err_map_a: assert property (
		pready |-> pslverr == (paddr > 8'h2c || paddr[1:0] != 2'b00))
		else $error("error flag wrong for address");
	rd_idle_a: assert property (
		!pready |-> prdata == 32'h0) else $error("read data outside answer");
endmodule // trg_top_checker

bind trg_top trg_top_checker chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_raw,
	.osc_drive);

// *** true_random_generator_tb.sv ***
// bench for trg_top: apb tasks, random sizes, health monitor
// assumes trg_pkg, trg_top and its checker compiled first
`timescale 1ns/1ps
`include "trg_cfg.svh"

module true_random_generator_tb;
	import trg_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] osc = 0;
	logic tog = 0;
	logic tg = 0;
	trg_osc_drive_t osc_drive;
	logic [31:0] rd;
	logic err;
	logic [5:0] v;
	logic [31:0] g;
	int n_fail = 0;
	int comparisons = 0;
	int sz;
	int t;
	int q;
	always #25 pclk = ~pclk;
	// toggling ring for the pairing stage
	always @(posedge pclk) tg <= tog && !tg;
	trg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr,
		.osc_raw(osc ^ {5'h00, tg}), .osc_drive);
	// ----
	// tasks
	// ----
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic poll(logic [7:0] a);
		do bus(0, a, 0);
		while (rd[1:0] !== 2'b00);
	endtask
	task automatic run;
		bus(1, `TRG_ADDR_CMD, 1);
		poll(`TRG_ADDR_CMD);
		bus(0, `TRG_ADDR_RESULT, 0);
	endtask
	task automatic ctl(logic [31:0] c);
		bus(1, `TRG_ADDR_CTRL, 0);
		bus(1, `TRG_ADDR_CTRL, c);
		bus(0, `TRG_ADDR_CTRL, 0);
		chk(rd, c);
	endtask
	function automatic logic [31:0] ones(int n);
		return n > 31 ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
	endfunction
	function automatic logic [31:0] cfgw(int z, l, r, c, m, d);
		return {8'h04, d[7:0], m[1:0], c[0], r[0], l[3:0], 2'b00, z[5:0]};
	endfunction
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		rd = $urandom(32'hab02);
		repeat (3) @(posedge pclk);
		presetn <= 1;
		bus(0, `TRG_ADDR_CFG, 0);
		chk(rd, `TRG_CFG_RESET);
		bus(0, 8'h30, 0);
		chk({rd[31:1], err}, 32'h1);
		g = ($urandom & 32'h7fff_fffe) | 32'h1;
		bus(1, `TRG_ADDR_GPOLY, g);
		bus(1, `TRG_ADDR_FPOLY, ~g | 32'h1);
		ctl(32'h17);
		chk(osc_drive.galois_poly | osc_drive.fibonacci_poly, 0);
		ctl(32'h28);
		chk(osc_drive.galois_poly, g[30:0]);
		chk(osc_drive.fibonacci_poly, 31'(~g | 32'h1));
		// one source, constant level, other rings off
		for (int i = 0; i < 8; i++) begin
			sz = i == 0 ? 32 : i == 1 ? 0 : $urandom_range(31, 1);
			t = $urandom_range(5, 0);
			v = 6'($urandom);
			osc <= v;
			bus(1, `TRG_ADDR_CFG, cfgw(sz, 0, 0, 0, 0, $urandom_range(2, 0)));
			ctl(32'h1 << t);
			chk(osc_drive.source_on_bits, 32'h1 << t);
			run;
			chk(rd, v[t] ? ones(sz) : 0);
		end
		// source xor and folding over periods
		osc <= 6'h3f;
		for (int k = 0; k < 4; k++) begin
			bus(1, `TRG_ADDR_CFG, cfgw(8, 0, 0, 0, 0, 0));
			ctl(ones(k + 1));
			run;
			chk(rd, k % 2 ? 0 : 32'hff);
			bus(1, `TRG_ADDR_CFG, cfgw(8, k, 1, 0, 0, 0));
			ctl(1);
			run;
			chk(rd, k % 2 ? 0 : 32'hff);
		end
		// pairing: alternating stream, then constant stream
		osc <= 0;
		tog <= 1;
		bus(1, `TRG_ADDR_CFG, cfgw(16, 0, 0, 1, 0, 0));
		ctl(1);
		run;
		chk(rd, rd[0] ? 32'hffff : 0);
		tog <= 0;
		osc <= 1;
		bus(1, `TRG_ADDR_CMD, 1);
		repeat (40) @(posedge pclk);
		bus(0, `TRG_ADDR_CMD, 0);
		chk(rd[0], 1);
		bus(1, `TRG_ADDR_CFG, cfgw(16, 0, 0, 0, 0, 0));
		run;
		chk(rd, 32'hffff);
		// long init delay holds off a one-bit result
		bus(1, `TRG_ADDR_CFG, cfgw(1, 0, 0, 0, 0, 0) | 32'hff00_0000);
		ctl(1);
		bus(1, `TRG_ADDR_CMD, 1);
		repeat (100) @(posedge pclk);
		bus(0, `TRG_ADDR_CMD, 0);
		chk(rd[0], 1);
		poll(`TRG_ADDR_CMD);
		bus(0, `TRG_ADDR_RESULT, 0);
		chk(rd, 1);
		// repeat test, then proportion test, each halting
		for (int p = 0; p < 3; p++) begin
			q = p % 2;
			t = $urandom_range(20, 3);
			bus(1, `TRG_ADDR_CFG, cfgw(32, 0, 0, 0, p, 0));
			bus(1, `TRG_ADDR_RCCFG, t);
			bus(1, `TRG_ADDR_APCFG, (t + q * 5) << 16 | t);
			ctl(32'h100 << q | 1);
			bus(1, `TRG_ADDR_MONCTL, 1 << q);
			poll(`TRG_ADDR_MONCTL);
			bus(0, q ? `TRG_ADDR_APSTAT : `TRG_ADDR_RCSTAT, 0);
			chk(rd, q ? (t - 1) << 16 | t : t << 8 | 1);
			bus(0, `TRG_ADDR_CTRL, 0);
			chk(rd, 32'h100 << q);
			bus(0, `TRG_ADDR_EVENT, 0);
			chk(rd, 1 << q);
			bus(1, `TRG_ADDR_EVENT, 3);
			bus(0, `TRG_ADDR_EVENT, 0);
			chk(rd, 0);
		end
		tally_and_finish;
	end
	// watchdog: run needs well under 40000 cycles
	initial begin
		#2000000;
		n_fail++;
		tally_and_finish;
	end
endmodule // true_random_generator_tb
